// >>> dv/apc_attr_unit_properties.sv
// checker of the attribute unit ports: read answers and pixel flow
// assumes apc_pkg compiled first and apc_cfg.svh on the include path
`timescale 1ns/1ps
`include "apc_cfg.svh"
module apc_attr_unit_properties
  import apc_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = `APC_BLINK_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rdata_valid,
  input wire logic        px_in_valid,
  input wire logic        px_in_ready,
  input wire apc_px_out_s px_out,
  input wire logic        px_out_valid,
  input wire logic        px_out_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rd_attr;
  logic rd_stat;
  assign rd_attr = io_rd && (io_addr == `APC_PORT_INDEX || io_addr == `APC_PORT_DATA_RD);
  assign rd_stat = io_rd && (io_addr == `APC_PORT_STAT_MONO || io_addr == `APC_PORT_STAT_COLOR);
  sequence s_take;
    px_in_valid && px_in_ready && !px_out_valid;
  endsequence
  sequence s_stall;
    px_out_valid && !px_out_ready;
  endsequence
  property p_rd_ans; rd_attr |=> io_rdata_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_quiet; !rd_attr |=> !io_rdata_valid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
  property p_stat; rd_stat |=> io_rdata == 8'h00; endproperty
  a_stat: assert property (p_stat) else $error("status read data");
  property p_hold; !io_rd |=> $stable(io_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_out; s_stall |=> px_out_valid && $stable(px_out); endproperty
  a_out: assert property (p_out) else $error("stalled pixel moved");
  property p_take; s_take |-> ##[2:6] px_out_valid; endproperty
  a_take: assert property (p_take) else $error("pixel not latched");
  property p_full; px_out_valid && !px_out_ready && !px_in_ready |=> !px_in_ready; endproperty
  a_full: assert property (p_full) else $error("full buffer drained");
  property p_rst; $fell(sys_rst) |-> !px_out_valid && px_in_ready && io_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule // apc_attr_unit_properties
bind apc_attr_unit apc_attr_unit_properties #(.BLINK_CYCLES(BLINK_CYCLES)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
  .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .px_in_valid(px_in_valid),
  .px_in_ready(px_in_ready), .px_out(px_out), .px_out_valid(px_out_valid),
  .px_out_ready(px_out_ready)
);

// >>> dv/apc_attr_unit_test.sv
// bench of the attribute unit: indexed register access and pixel lookups
// assumes design, checker and sink model compiled first
`timescale 1ns/1ps
`include "apc_cfg.svh"
module apc_attr_unit_test
  import apc_pkg::*;
;
  logic        core_clk, sys_rst, io_wr, io_rd, io_word, io16_en, linear_256_mode;
  logic        px_in_valid, px_in_ready, px_out_valid, px_out_ready, stall, io_rdata_valid;
  logic        lo, hi;
  logic [15:0] io_addr, io_wdata;
  logic [7:0]  io_rdata, v;
  logic [5:0]  pal [16];
  apc_px_in_s  px_in;
  apc_px_out_s px_out, got;
  int          n_got, failures, n_tests, k;
  apc_attr_unit #(.BLINK_CYCLES(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_word(io_word), .io16_en(io16_en), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .linear_256_mode(linear_256_mode), .px_in(px_in), .px_in_valid(px_in_valid),
    .px_in_ready(px_in_ready), .px_out(px_out), .px_out_valid(px_out_valid),
    .px_out_ready(px_out_ready)
  );
  apc_px_sink u_sink (
    .core_clk(core_clk), .sys_rst(sys_rst), .stall(stall), .px_out(px_out),
    .px_out_valid(px_out_valid), .px_out_ready(px_out_ready), .got(got), .n_got(n_got)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    v = io_rdata;
  endtask
  // toggle back to index, then select
  task automatic sel(input logic [7:0] i);
    rd(`APC_PORT_STAT_COLOR);
    wr(`APC_PORT_INDEX, {8'h00, i});
  endtask
  task automatic w(input logic [7:0] i, input logic [7:0] d);
    sel(i);
    wr(`APC_PORT_INDEX, {8'h00, d});
  endtask
  task automatic rr(input logic [7:0] i);
    sel(i);
    rd(`APC_PORT_DATA_RD);
  endtask
  task automatic push(input apc_px_in_s p);
    @(negedge core_clk);
    px_in = p;
    px_in_valid = 1'b1;
    while (!px_in_ready) @(negedge core_clk);
    @(negedge core_clk);
    px_in_valid = 1'b0;
  endtask
  task automatic pix(input apc_px_in_s p);
    k = n_got;
    push(p);
    repeat (20) if (n_got == k) @(negedge core_clk);
  endtask
  // mode written through index 0x30 keeps palette source on
  task automatic pc(input logic [7:0] m, input logic [3:0] c, input logic ab, sp, sw,
                    input logic [7:0] ev, input logic [3:0] ep);
    w(8'h30, m);
    pix('{8'hA5, c, ab, sp, sw});
    chk({4'h0, got}, {4'h0, ev, ep});
  endtask
  task automatic results;
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // whole run is some 500 cycles
  initial begin
    #60000;
    failures++;
    results();
  end
  initial begin
    {sys_rst, io_wr, io_rd, io_word, io16_en, linear_256_mode, px_in_valid, stall} = 8'h80;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    px_in = '0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rr(8'h10);
    chk(v, 8'h00);
    sel(8'h25);
    rd(`APC_PORT_INDEX);
    chk(v, 8'h25);
    for (int i = 0; i < 16; i++) begin
      pal[i] = 6'(i * 7 + 1);
      w(8'(i), {2'b11, pal[i]});
    end
    for (int i = 0; i < 16; i++) begin
      rr(8'(i));
      chk(v, {2'b00, pal[i]});
    end
    w(8'h20, 8'h3F);
    rd(`APC_PORT_DATA_RD);
    chk(v, {2'b00, pal[0]});
    io16_en = 1'b1;
    io_word = 1'b1;
    wr(`APC_PORT_INDEX, 16'h5A11);
    io_word = 1'b0;
    wr(`APC_PORT_INDEX, 16'h0011);
    rd(`APC_PORT_DATA_RD);
    chk(v, 8'h5A);
    w(8'h10, 8'hFF);
    wr(`APC_PORT_INDEX, 16'h0015);
    wr(`APC_PORT_INDEX, 16'h00FF);
    rd(`APC_PORT_DATA_RD);
    chk(v, 8'h00);
    rr(8'h10);
    chk(v, 8'hEF);
    w(8'h12, 8'h0F);
    w(8'h13, 8'h07);
    w(8'h14, 8'h0D);
    pix('{8'h00, 4'h2, 1'b0, 1'b0, 1'b0});
    chk({8'h00, got.video}, 16'h005A);
    sel(8'h20);
    pc(8'h00, 4'hB, 1'b1, 1'b0, 1'b0, {2'b11, pal[11]}, 4'h7);
    pc(8'h08, 4'h3, 1'b0, 1'b0, 1'b0, {2'b11, pal[11]}, 4'h7);
    pc(8'h09, 4'h3, 1'b1, 1'b0, 1'b0, {2'b11, pal[11]}, 4'h7);
    pc(8'h80, 4'h2, 1'b0, 1'b0, 1'b0, {4'hD, pal[2][3:0]}, 4'h7);
    pc(8'h00, 4'h2, 1'b0, 1'b0, 1'b0, {2'b11, pal[2]}, 4'h7);
    pc(8'h20, 4'h1, 1'b0, 1'b1, 1'b0, {2'b11, pal[1]}, 4'h0);
    pc(8'h00, 4'h1, 1'b0, 1'b1, 1'b0, {2'b11, pal[1]}, 4'h7);
    pc(8'h00, 4'h1, 1'b0, 1'b0, 1'b1, {2'b11, pal[1]}, 4'h0);
    linear_256_mode = 1'b1;
    pc(8'h80, 4'h1, 1'b0, 1'b0, 1'b0, 8'hA5, 4'h7);
    linear_256_mode = 1'b0;
    w(8'h30, 8'h08);
    {lo, hi} = 2'b00;
    for (int i = 0; i < 12; i++) begin
      repeat (i % 3) @(negedge core_clk);
      pix('{8'h00, 4'h3, 1'b1, 1'b0, 1'b0});
      lo |= got.video == {2'b11, pal[3]};
      hi |= got.video == {2'b11, pal[11]};
    end
    chk({14'h0000, lo, hi}, 16'h0003);
    w(8'h30, 8'h40);
    stall = 1'b1;
    k = n_got;
    for (int i = 1; i < 4; i++) push('{8'h00, 4'(i), 1'b0, 1'b0, 1'b0});
    repeat (3) @(negedge core_clk);
    chk({15'h0000, px_in_ready}, 16'h0000);
    stall = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(16'(n_got - k), 16'h0002);
    repeat (7) @(negedge core_clk);
    chk(16'(n_got - k), 16'h0003);
    chk({8'h00, got.video}, {10'h003, pal[3]});
    results();
  end
endmodule // apc_attr_unit_test

// >>> dv/apc_px_sink.sv
// downstream pixel sink model, stalls on command
// assumes stall changes away from the rising clock edge
`timescale 1ns/1ps
module apc_px_sink
  import apc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire apc_px_out_s px_out,
  input  wire logic        px_out_valid,
  output logic             px_out_ready,
  output apc_px_out_s      got,
  output int               n_got
);
  assign px_out_ready = !stall;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      got <= '0;
      n_got <= 0;
    end else if (px_out_valid && px_out_ready) begin
      got <= px_out;
      n_got <= n_got + 1;
    end
  end
endmodule // apc_px_sink

// >>> verilog/apc_attr_unit.sv
// attribute_unit: host index/data access, 16-entry palette, mode control, blink
// assumes the host i/o strobes and pixel stream are synchronous to core_clk
// Behaviour
// - palette-source bit 1 blocks host palette writes; pixels use palette lookups.
// - palette-source bit 0 allows palette writes; output is overscan colour.
// - index bits 4:0 select the register reached by the data phase.
// - index register written at 3C0 while toggle is in index state, read at 3C0 in either state.
// - indexed registers read at 3C1, written at 3C0 in data state.
// - four plane bits address one of 16 entries; entry goes to latch.
// - entries hold six colour bits; bits 7 and 6 read zero.
// - secondary-select 1 takes secondary blue/green from colour select bits 0,1.
// - secondary-select 0 takes secondary blue/green from entry bits 4,5.
// - linear 256-colour mode passes the memory data byte to the latch in place of the palette lookup.
// - half-rate bit outputs one pixel per two clocks, four per character.
// - mode bit 5 set suppresses panning in the split-screen region.
// - panning is not applied where the secondary window overlays.
// - text blink applies to characters with attribute bit 7 set.
// - graphics blink applies to pixels with intensity plane bit set.
// - blink toggles palette address bit 3 at the blink rate.
// - with blink on, non-blinking pixels use the upper eight entries.
// - with blink off, palette address bit 3 comes from video data.
// - a read of the input status port resets the toggle to index.
// - every byte write to 3C0 flips the toggle, except in a cycle with a status port read, which sets it to index.
// - a 16-bit word write to 3C0 leaves the toggle in index state.
// - mode bit 0 selects graphics processing when 1, text when 0.
`timescale 1ns/1ps
`include "apc_cfg.svh"

module apc_attr_unit
  import apc_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = `APC_BLINK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_word,
  input  wire logic        io16_en,
  input  wire logic [15:0] io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_valid,
  input  wire logic        linear_256_mode,
  input  wire apc_px_in_s  px_in,
  input  wire logic        px_in_valid,
  output logic             px_in_ready,
  output apc_px_out_s      px_out,
  output logic             px_out_valid,
  input  wire logic        px_out_ready
);

  apc_toggle_e toggle;
  logic [5:0]  index_reg;
  logic [5:0]  palette_entries [16];
  logic [7:0]  mode_ctl;
  logic [7:0]  overscan;
  logic [7:0]  plane_en;
  logic [7:0]  pan_reg;
  logic [7:0]  color_sel;
  logic [7:0]  misc_reg;
  logic [7:0]  misc1_reg;

  // host access decode
  logic        wr_idx_port;
  logic        word_wr;
  logic        byte_wr;
  logic        stat_rd;
  logic        reg_wr;
  logic [4:0]  reg_wr_sel;
  logic [7:0]  reg_wr_data;
  logic [7:0]  next_rdata;
  logic [4:0]  sel;

  assign sel         = index_reg[`APC_IDX_SEL_MSB:0];
  assign wr_idx_port = io_wr && (io_addr == `APC_PORT_INDEX);
  assign word_wr     = wr_idx_port && io_word && io16_en;
  assign byte_wr     = wr_idx_port && !word_wr;
  assign stat_rd     = io_rd && ((io_addr == `APC_PORT_STAT_MONO) ||
                                 (io_addr == `APC_PORT_STAT_COLOR));
  assign reg_wr      = word_wr || (byte_wr && (toggle == APC_TGL_DATA));
  assign reg_wr_data = word_wr ? io_wdata[15:8] : io_wdata[7:0];
  assign reg_wr_sel  = word_wr ? io_wdata[`APC_IDX_SEL_MSB:0] : sel;

  // index/data toggle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle <= APC_TGL_INDEX;
    end else if (stat_rd) begin
      toggle <= APC_TGL_INDEX;
    end else if (word_wr) begin
      toggle <= APC_TGL_INDEX;
    end else if (byte_wr) begin
      toggle <= (toggle == APC_TGL_INDEX) ? APC_TGL_DATA : APC_TGL_INDEX;
    end
  end

  // index register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      index_reg <= `APC_RST_INDEX;
    end else if (word_wr || (byte_wr && (toggle == APC_TGL_INDEX))) begin
      index_reg <= io_wdata[5:0];
    end
  end

  // palette entries, written only while the pipeline is off the palette
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        palette_entries[i] <= `APC_RST_INDEX;
      end
    end else if (reg_wr && (reg_wr_sel <= `APC_REG_PAL_LAST) &&
                 !index_reg[`APC_IDX_PAL_SRC]) begin
      palette_entries[reg_wr_sel[3:0]] <= reg_wr_data[5:0];
    end
  end

  // control registers, one block per index; unused indexes match none
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ctl <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_MODE)) begin
      mode_ctl <= reg_wr_data & `APC_MASK_MODE;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overscan <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_OVERSCAN)) begin
      overscan <= reg_wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      plane_en <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_PLANE_EN)) begin
      plane_en <= reg_wr_data & `APC_MASK_PLANE_EN;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pan_reg <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_PAN)) begin
      pan_reg <= reg_wr_data & `APC_MASK_LOW4;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      color_sel <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_COLOR_SEL)) begin
      color_sel <= reg_wr_data & `APC_MASK_LOW4;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc_reg <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_MISC)) begin
      misc_reg <= reg_wr_data & `APC_MASK_MISC;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc1_reg <= `APC_RST_REG;
    end else if (reg_wr && (reg_wr_sel == `APC_REG_MISC1)) begin
      misc1_reg <= reg_wr_data & `APC_MASK_MISC1;
    end
  end

  // read data mux
  always_comb begin
    next_rdata = 8'h00;
    if (io_addr == `APC_PORT_INDEX) begin
      next_rdata = {2'b00, index_reg} & `APC_MASK_INDEX;
    end else if (io_addr == `APC_PORT_DATA_RD) begin
      if (sel <= `APC_REG_PAL_LAST) begin
        next_rdata = {2'b00, palette_entries[sel[3:0]]};
      end else begin
        case (sel)
          `APC_REG_MODE:      next_rdata = mode_ctl;
          `APC_REG_OVERSCAN:  next_rdata = overscan;
          `APC_REG_PLANE_EN:  next_rdata = plane_en;
          `APC_REG_PAN:       next_rdata = pan_reg;
          `APC_REG_COLOR_SEL: next_rdata = color_sel;
          `APC_REG_MISC:      next_rdata = misc_reg;
          `APC_REG_MISC1:     next_rdata = misc1_reg;
          default:            next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd && ((io_addr == `APC_PORT_INDEX) ||
                                  (io_addr == `APC_PORT_DATA_RD));
      if (io_rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

  // blink rate divider
  logic [31:0] blink_cnt;
  logic        blink_phase;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= BLINK_CYCLES - 1) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // two-entry input buffer
  apc_px_in_s buf_mem [2];
  logic       buf_wp;
  logic       buf_rp;
  logic [1:0] buf_cnt;
  logic       buf_push;
  logic       buf_pop;
  logic       buf_valid;
  apc_px_in_s cur;

  assign px_in_ready = (buf_cnt != 2'd2);
  assign buf_valid   = (buf_cnt != 2'd0);
  assign buf_push    = px_in_valid && px_in_ready;
  assign cur         = buf_mem[buf_rp];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_wp <= !buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= !buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (buf_push) begin
      buf_mem[buf_wp] <= px_in;
    end
  end

  // half-rate pacing
  logic half_phase;
  logic lat_load;

  assign lat_load = buf_valid && (!px_out_valid || px_out_ready) &&
                    (!mode_ctl[`APC_MODE_HALF_RATE] || half_phase);
  assign buf_pop  = lat_load;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_phase <= 1'b0;
    end else if (!mode_ctl[`APC_MODE_HALF_RATE]) begin
      half_phase <= 1'b0;
    end else begin
      half_phase <= !half_phase;
    end
  end

  // palette lookup
  logic [3:0] masked_idx;
  logic       blink_src;
  logic [3:0] pal_addr;
  logic [5:0] entry;
  logic       sec_b;
  logic       sec_g;
  logic [7:0] next_video;
  logic [3:0] next_pan;

  always_comb begin
    masked_idx = cur.color_index & plane_en[3:0];
    blink_src  = mode_ctl[`APC_MODE_GRAPHICS] ? masked_idx[3]
                                              : cur.attr_blink;
    pal_addr   = masked_idx;
    if (mode_ctl[`APC_MODE_BLINK]) begin
      pal_addr[3] = blink_src ? blink_phase : 1'b1;
    end
    entry = palette_entries[pal_addr];
    if (mode_ctl[`APC_MODE_SEC_SEL]) begin
      sec_b = color_sel[0];
      sec_g = color_sel[1];
    end else begin
      sec_b = entry[4];
      sec_g = entry[5];
    end
    if (!index_reg[`APC_IDX_PAL_SRC]) begin
      next_video = overscan;
    end else if (linear_256_mode) begin
      next_video = cur.mem_byte;
    end else begin
      next_video = {color_sel[3:2], sec_g, sec_b, entry[3:0]};
    end
    if (cur.second_win || (cur.split_region && mode_ctl[`APC_MODE_PAN_OFF])) begin
      next_pan = 4'h0;
    end else begin
      next_pan = pan_reg[3:0];
    end
  end

  // output latch data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      px_out <= '0;
    end else if (lat_load) begin
      px_out.video     <= next_video;
      px_out.pan_shift <= next_pan;
    end
  end

  // output latch valid, held until taken
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      px_out_valid <= 1'b0;
    end else if (lat_load) begin
      px_out_valid <= 1'b1;
    end else if (px_out_ready) begin
      px_out_valid <= 1'b0;
    end
  end

endmodule // apc_attr_unit

// >>> verilog/apc_cfg.svh
// constants of the attribute palette controller: ports, indexes, fields, resets
// assumes 16-bit host i/o addresses and 8-bit data lanes
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

// host i/o ports
`define APC_PORT_INDEX      16'h03C0
`define APC_PORT_DATA_RD    16'h03C1
`define APC_PORT_STAT_MONO  16'h03BA
`define APC_PORT_STAT_COLOR 16'h03DA

// index register fields
`define APC_IDX_SEL_MSB     4
`define APC_IDX_PAL_SRC     5

// indexed register addresses
`define APC_REG_PAL_LAST    5'h0F
`define APC_REG_MODE        5'h10
`define APC_REG_OVERSCAN    5'h11
`define APC_REG_PLANE_EN    5'h12
`define APC_REG_PAN         5'h13
`define APC_REG_COLOR_SEL   5'h14
`define APC_REG_MISC        5'h16
`define APC_REG_MISC1       5'h17

// mode control fields
`define APC_MODE_GRAPHICS   0
`define APC_MODE_BLINK      3
`define APC_MODE_PAN_OFF    5
`define APC_MODE_HALF_RATE  6
`define APC_MODE_SEC_SEL    7

// writable bits per register, reserved bits stay zero
`define APC_MASK_PAL        8'h3F
`define APC_MASK_MODE       8'hEF
`define APC_MASK_PLANE_EN   8'h3F
`define APC_MASK_LOW4       8'h0F
`define APC_MASK_MISC       8'hF3
`define APC_MASK_MISC1      8'h80
`define APC_MASK_INDEX      8'h3F

// reset values
`define APC_RST_REG         8'h00
`define APC_RST_INDEX       6'h00

// blink half period in pixel clocks
`define APC_BLINK_CYCLES    8388608

`endif

// >>> verilog/apc_pkg.sv
// types of the attribute palette controller
// assumes apc_cfg.svh is included by the design file
package apc_pkg;

  typedef enum logic [0:0] {
    APC_TGL_INDEX = 1'b0,
    APC_TGL_DATA  = 1'b1
  } apc_toggle_e;

  // one pixel from display memory
  typedef struct packed {
    logic [7:0] mem_byte;     // raw byte, used in linear 256-colour modes
    logic [3:0] color_index;  // one bit per plane, or text fg/bg nibble
    logic       attr_blink;   // text attribute bit 7
    logic       split_region; // pixel lies in the split-screen region
    logic       second_win;   // secondary window overlays the primary one
  } apc_px_in_s;

  // one pixel to the video output latch
  typedef struct packed {
    logic [7:0] video;        // pb pg pr si sb sg, then colour select 3:2
    logic [3:0] pan_shift;    // panning to apply downstream
  } apc_px_out_s;

endpackage
